/* File: hdl/bad_pkg.sv */
// Purpose: Constants for the board address decoder.
// Assumes: Standard decode pattern on the eight high address bits.
// Notes: Page values are the high address byte.
package bad_pkg;
  localparam int ADDR_W = 16;
  localparam int HI_LSB = 8;
  localparam int HI_W = 8;
  localparam int LUT_W = 5;
  localparam int LUT_DEPTH = 512;
  // Lookup output bit positions.
  localparam int B_CODE_LO = 1;
  localparam int B_CODE_HI = 2;
  localparam int B_GRP2_N = 3;
  localparam int B_GRP1_N = 4;
  // Codes on bits 2:1.
  localparam logic [1:0] C1_ROM_JUMP = 2'h3;
  localparam logic [1:0] C1_ROM_NORM = 2'h2;
  localparam logic [1:0] C1_RAM = 2'h1;
  localparam logic [1:0] C1_TIMER = 2'h0;
  localparam logic [1:0] C2_PARALLEL = 2'h3;
  localparam logic [1:0] C2_SERIAL = 2'h2;
  localparam logic [1:0] C2_SYSTEM = 2'h1;
  localparam logic [1:0] C2_CONTROL = 2'h0;
  // Memory pages.
  localparam logic [7:0] PG_JUMP_LO = 8'h00;
  localparam logic [7:0] PG_JUMP_HI = 8'h07;
  localparam logic [7:0] PG_NORM_LO = 8'hd8;
  localparam logic [7:0] PG_NORM_HI = 8'hdf;
  localparam logic [7:0] PG_RAM = 8'hd0;
  localparam logic [7:0] PG_TIMER = 8'hd1;
  // Port addresses; masks mark don't-care bits sub-decoded low.
  localparam logic [7:0] IO_SERIAL_A = 8'h04;
  localparam logic [7:0] IO_SERIAL_B = 8'h12;
  localparam logic [7:0] IO_PARALLEL = 8'h14;
  localparam logic [7:0] IO_SYSTEM = 8'h02;
  localparam logic [7:0] IO_CONTROL = 8'hf3;
  localparam logic [7:0] IO_PAIR_MASK = 8'hfe;
  localparam logic [7:0] IO_FULL_MASK = 8'hff;
  // Control port data bits.
  localparam int CTL_JUMP_BIT = 0;
  localparam int CTL_MEM_BIT = 1;
  localparam int CTL_DELAY = 3;
  localparam logic [4:0] LUT_NONE = 5'h1f;
endpackage

/* File: hdl/bad_decoder.sv */
// Purpose: Board address decoder producing active-low chip enables.
// Assumes: Strobes are synchronous levels sampled on clk.
// Notes: Enables are combinational from address, status and the registered control enables.
`timescale 1ns/1ps
`default_nettype none
module bad_decoder #(
  parameter bit SYS_TO_SERIAL = 1'b1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [bad_pkg::ADDR_W-1:0] addr,
  input wire logic io_not_mem,
  input wire logic read_status,
  input wire logic interrupt_ack_strobe_n,
  input wire logic rd_strobe_n,
  input wire logic wr_strobe_n,
  input wire logic memory_write_strobe_n,
  input wire logic internal_write_strobe_n,
  input wire logic ctl_data_jump,
  input wire logic ctl_data_mem,
  output logic rom_en_n,
  output logic ram_en_n,
  output logic timer_en_n,
  output logic parallel_en_n,
  output logic serial_en_n,
  output logic control_en_n,
  output logic ram_timer_wr_n,
  output logic power_on_jump_enable,
  output logic onboard_memory_enable
);
  import bad_pkg::*;

  // ****************************************************************
  // Lookup pattern
  // ****************************************************************
  logic [LUT_W-1:0] decode_lookup_rom [LUT_DEPTH];

  function automatic logic [LUT_W-1:0] pattern(input logic io,
                                               input logic [7:0] pg);
    logic [LUT_W-1:0] v;
    v = LUT_NONE;
    if (!io) begin
      if (pg >= PG_NORM_LO && pg <= PG_NORM_HI) begin
        v = {2'b01, C1_ROM_NORM, 1'b1};
      end else if (pg == PG_RAM) begin
        v = {2'b01, C1_RAM, 1'b1};
      end else if (pg == PG_TIMER) begin
        v = {2'b01, C1_TIMER, 1'b1};
      end else if (pg <= PG_JUMP_HI) begin
        v = {2'b01, C1_ROM_JUMP, 1'b1};
      end
    end else begin
      // low bit don't-care for port pairs
      if ((pg & IO_PAIR_MASK) == IO_SERIAL_A ||
          (pg & IO_PAIR_MASK) == IO_SERIAL_B) begin
        v = {2'b10, C2_SERIAL, 1'b1};
      end else if ((pg & IO_PAIR_MASK) == IO_PARALLEL) begin
        v = {2'b10, C2_PARALLEL, 1'b1};
      end else if ((pg & IO_PAIR_MASK) == IO_SYSTEM) begin
        v = {2'b10, C2_SYSTEM, 1'b1};
      end else if ((pg & IO_FULL_MASK) == IO_CONTROL) begin
        v = {2'b10, C2_CONTROL, 1'b1};
      end
    end
    return v;
  endfunction

  // table never sets both group bits low
  generate
    for (genvar i = 0; i < LUT_DEPTH; i++) begin : g_lut
      localparam logic [HI_W:0] IDX = (HI_W+1)'(i);
      assign decode_lookup_rom[i] = pattern(IDX[HI_W], IDX[HI_W-1:0]);
    end
  endgenerate

  // ****************************************************************
  // Lookup stage
  // ****************************************************************
  // nine-bit lookup index
  wire logic [HI_W:0] lut_idx = {io_not_mem, addr[ADDR_W-1:HI_LSB]};
  wire logic interrupt_ack_active = ~interrupt_ack_strobe_n;
  wire logic [LUT_W-1:0] lut_raw = decode_lookup_rom[lut_idx];
  wire logic [LUT_W-1:0] lut_out = interrupt_ack_active ? LUT_NONE : lut_raw;
  wire logic grp1_n = lut_out[B_GRP1_N];
  wire logic grp2_n = lut_out[B_GRP2_N];
  wire logic [1:0] code = lut_out[B_CODE_HI:B_CODE_LO];

  // ****************************************************************
  // Dual group decoder
  // ****************************************************************
  // group 1 half enable
  wire logic g1_on = ~grp1_n & onboard_memory_enable;
  wire logic g2_on = ~grp2_n;
  wire logic d_norm = g1_on & (code == C1_ROM_NORM);
  wire logic d_ram = g1_on & (code == C1_RAM);
  wire logic d_timer = g1_on & (code == C1_TIMER);
  // jump location gated by its own enable
  wire logic d_jump = ~grp1_n & power_on_jump_enable &
                      (code == C1_ROM_JUMP);
  wire logic d_par = g2_on & (code == C2_PARALLEL);
  wire logic d_ser = g2_on & (code == C2_SERIAL);
  wire logic d_sys = g2_on & (code == C2_SYSTEM);
  wire logic d_ctl = g2_on & (code == C2_CONTROL);
  // system port routed to exactly one target
  wire logic sys_ser = d_sys & SYS_TO_SERIAL;
  wire logic sys_par = d_sys & ~SYS_TO_SERIAL;
  wire logic rom_read_qualifier = (d_norm | d_jump) & read_status;

  assign rom_en_n = ~rom_read_qualifier;
  // RAM and timer on memory reads and writes alike
  assign ram_en_n = ~d_ram;
  assign timer_en_n = ~d_timer;
  assign serial_en_n = ~(d_ser | sys_ser);
  assign parallel_en_n = ~(d_par | sys_par);
  assign control_en_n = ~d_ctl;
  // I/O cycles use the internal write strobe
  assign ram_timer_wr_n = io_not_mem ? internal_write_strobe_n :
                                       memory_write_strobe_n;

  // ****************************************************************
  // Control enable delay
  // ****************************************************************
  // Strobe edges are found on clk, so each strobe pulse must last a cycle.
  logic [CTL_DELAY:0] jump_sr_r;
  logic [CTL_DELAY:0] mem_sr_r;
  logic strobe_d_r;
  wire logic strobe = ~rd_strobe_n | ~wr_strobe_n;
  wire logic strobe_end = strobe_d_r & ~strobe;
  wire logic ctl_write_end = strobe_end & ~control_en_n & ~read_status;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      jump_sr_r <= '0;
      mem_sr_r <= '0;
      strobe_d_r <= 1'b0;
    end else if (clk_en) begin
      strobe_d_r <= strobe;
      // load on write, then shift each strobe
      if (ctl_write_end) begin
        jump_sr_r <= {jump_sr_r[CTL_DELAY:1], ctl_data_jump};
        mem_sr_r <= {mem_sr_r[CTL_DELAY:1], ctl_data_mem};
      end else if (strobe_end) begin
        jump_sr_r <= {jump_sr_r[CTL_DELAY-1:0], jump_sr_r[0]};
        mem_sr_r <= {mem_sr_r[CTL_DELAY-1:0], mem_sr_r[0]};
      end
    end
  end

  assign power_on_jump_enable = ~jump_sr_r[CTL_DELAY];
  assign onboard_memory_enable = ~mem_sr_r[CTL_DELAY];

  // ****************************************************************
  // Checks
  // ****************************************************************
  wire logic [HI_W-1:0] hi_pg = addr[ADDR_W-1:HI_LSB];
  wire logic mem_cyc = ~interrupt_ack_active & ~io_not_mem;
  wire logic io_cyc = ~interrupt_ack_active & io_not_mem;

  sequence s_ctl_wr;
    clk_en && ctl_write_end;
  endsequence
  sequence s_ctl_shift;
    clk_en && strobe_end && !ctl_write_end;
  endsequence
  sequence s_norm_rd;
    mem_cyc && read_status && onboard_memory_enable &&
      hi_pg >= PG_NORM_LO && hi_pg <= PG_NORM_HI;
  endsequence
  sequence s_jump_rd;
    mem_cyc && read_status && power_on_jump_enable && hi_pg <= PG_JUMP_HI;
  endsequence
  sequence s_ram_hit;
    mem_cyc && onboard_memory_enable && hi_pg == PG_RAM;
  endsequence
  sequence s_timer_hit;
    mem_cyc && onboard_memory_enable && hi_pg == PG_TIMER;
  endsequence
  sequence s_ser_hit;
    io_cyc && (hi_pg & IO_PAIR_MASK) == IO_SERIAL_A;
  endsequence
  sequence s_par_hit;
    io_cyc && (hi_pg & IO_PAIR_MASK) == IO_PARALLEL;
  endsequence
  sequence s_sys_hit;
    io_cyc && (hi_pg & IO_PAIR_MASK) == IO_SYSTEM;
  endsequence

  group_excl_a: assert property (
    @(posedge clk) disable iff (!rstn) !(~grp1_n & ~grp2_n))
    else $error("both group markers low");

  idle_none_a: assert property (
    @(posedge clk) disable iff (!rstn) (grp1_n && grp2_n) |->
    (rom_en_n & ram_en_n & timer_en_n & serial_en_n & parallel_en_n &
     control_en_n))
    else $error("enable with no group selected");

  ack_blocks_a: assert property (
    @(posedge clk) disable iff (!rstn)
    interrupt_ack_active |-> (rom_en_n & ram_en_n & timer_en_n &
      serial_en_n & parallel_en_n & control_en_n))
    else $error("enable during interrupt acknowledge");

  rom_write_a: assert property (
    @(posedge clk) disable iff (!rstn) !read_status |-> rom_en_n)
    else $error("rom enabled on write");

  mem_gate_a: assert property (
    @(posedge clk) disable iff (!rstn)
    !onboard_memory_enable |-> (ram_en_n & timer_en_n))
    else $error("group 1 enable while memory disabled");

  ram_page_a: assert property (
    @(posedge clk) disable iff (!rstn)
    !ram_en_n |-> (hi_pg == PG_RAM && !io_not_mem))
    else $error("ram outside its page");

  timer_page_a: assert property (
    @(posedge clk) disable iff (!rstn)
    !timer_en_n |-> (hi_pg == PG_TIMER && !io_not_mem))
    else $error("timer outside its page");

  rom_page_a: assert property (
    @(posedge clk) disable iff (!rstn) !rom_en_n |-> (mem_cyc &&
    ((hi_pg >= PG_NORM_LO && hi_pg <= PG_NORM_HI) || hi_pg <= PG_JUMP_HI)))
    else $error("rom outside its pages");

  rom_norm_a: assert property (
    @(posedge clk) disable iff (!rstn) s_norm_rd |-> !rom_en_n)
    else $error("normal rom not enabled");

  jump_rd_a: assert property (
    @(posedge clk) disable iff (!rstn) s_jump_rd |-> !rom_en_n)
    else $error("jump rom not enabled");

  jump_off_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (!power_on_jump_enable && !onboard_memory_enable) |-> rom_en_n)
    else $error("rom enabled while both locations disabled");

  ram_hit_a: assert property (
    @(posedge clk) disable iff (!rstn) s_ram_hit |-> !ram_en_n)
    else $error("ram not enabled");

  timer_hit_a: assert property (
    @(posedge clk) disable iff (!rstn) s_timer_hit |-> !timer_en_n)
    else $error("timer not enabled");

  ctl_port_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (io_cyc && hi_pg == IO_CONTROL) |-> !control_en_n)
    else $error("control port not enabled");

  ser_hit_a: assert property (
    @(posedge clk) disable iff (!rstn) s_ser_hit |-> !serial_en_n)
    else $error("serial port not enabled");

  par_hit_a: assert property (
    @(posedge clk) disable iff (!rstn) s_par_hit |-> !parallel_en_n)
    else $error("parallel port not enabled");

  sys_route_a: assert property (
    @(posedge clk) disable iff (!rstn) s_sys_hit |-> (SYS_TO_SERIAL ?
    (!serial_en_n && parallel_en_n) : (!parallel_en_n && serial_en_n)))
    else $error("system port routed wrongly");

  port_excl_a: assert property (
    @(posedge clk) disable iff (!rstn) !(~serial_en_n & ~parallel_en_n))
    else $error("serial and parallel both enabled");

  all_onehot_a: assert property (
    @(posedge clk) disable iff (!rstn)
    $onehot0(~{rom_en_n, ram_en_n, timer_en_n, serial_en_n,
               parallel_en_n, control_en_n}))
    else $error("more than one enable asserted");

  io_wr_a: assert property (
    @(posedge clk) disable iff (!rstn)
    io_not_mem |-> ram_timer_wr_n == internal_write_strobe_n)
    else $error("wrong write strobe in io space");

  mem_wr_a: assert property (
    @(posedge clk) disable iff (!rstn)
    !io_not_mem |-> ram_timer_wr_n == memory_write_strobe_n)
    else $error("wrong write strobe in memory space");

  hi_only_a: assert property (
    @(posedge clk) disable iff (!rstn)
    ($stable(hi_pg) && $stable(io_not_mem) && $stable(read_status) &&
     $stable(interrupt_ack_strobe_n) && $stable(power_on_jump_enable) &&
     $stable(onboard_memory_enable)) |-> $stable({rom_en_n, ram_en_n,
     timer_en_n, serial_en_n, parallel_en_n, control_en_n}))
    else $error("enable moved without a decode input change");

  ctl_hold_a: assert property (
    @(posedge clk) disable iff (!rstn)
    s_ctl_wr |=> $stable(onboard_memory_enable))
    else $error("control bit applied too early");

  ctl_load_a: assert property (
    @(posedge clk) disable iff (!rstn) s_ctl_wr |=>
    (mem_sr_r[0] == $past(ctl_data_mem) &&
     jump_sr_r[0] == $past(ctl_data_jump)))
    else $error("control write not loaded");

  ctl_shift_a: assert property (
    @(posedge clk) disable iff (!rstn) s_ctl_shift |=>
    mem_sr_r[CTL_DELAY:1] == $past(mem_sr_r[CTL_DELAY-1:0]))
    else $error("control delay did not shift");

  // Clock enable low freezes the control state.
  freeze_a: assert property (
    @(posedge clk) disable iff (!rstn)
    !clk_en |=> ($stable(mem_sr_r) && $stable(jump_sr_r)))
    else $error("control state moved while frozen");

  reset_en_a: assert property (
    @(posedge clk) !rstn |=> (power_on_jump_enable & onboard_memory_enable))
    else $error("reset did not enable memory");
endmodule
`default_nettype wire

/* File: verification/bad_cpu_model.sv */
// Purpose: Processor model that runs bus cycles against the decoder.
// Assumes: Every signal changes on the falling clock edge.
// Notes: A released address shows its inverse, never the last value.
`timescale 1ns/1ps
`default_nettype none
module bad_cpu_model (
  input wire logic clk,
  input wire logic [6:0] en_n,
  output logic [15:0] addr,
  output logic io_not_mem,
  output logic read_status,
  output logic interrupt_ack_strobe_n,
  output logic rd_strobe_n,
  output logic wr_strobe_n,
  output logic memory_write_strobe_n,
  output logic internal_write_strobe_n
);
  initial begin
    addr = 16'h0000;
    io_not_mem = 1'b0;
    read_status = 1'b1;
    {interrupt_ack_strobe_n, rd_strobe_n, wr_strobe_n} = 3'h7;
    {memory_write_strobe_n, internal_write_strobe_n} = 2'h3;
  end
  // The strobe stays low for two clocks; the enables are sampled in the
  // second so that address and status have long settled.
  task automatic cycle(input logic [7:0] pg, input logic io, input logic rd,
                       input logic ack, output logic [6:0] seen);
    @(negedge clk);
    addr = {pg, 8'h5a};
    io_not_mem = io;
    read_status = rd;
    if (ack) begin
      interrupt_ack_strobe_n = 1'b0;
    end else if (rd) begin
      rd_strobe_n = 1'b0;
    end else begin
      wr_strobe_n = 1'b0;
      internal_write_strobe_n = 1'b0;
      memory_write_strobe_n = io;
    end
    @(negedge clk);
    seen = en_n;
    @(negedge clk);
    {interrupt_ack_strobe_n, rd_strobe_n, wr_strobe_n} = 3'h7;
    {memory_write_strobe_n, internal_write_strobe_n} = 2'h3;
    // Address and status outlive the strobe by a cycle: the control
    // write is taken at the edge that sees the strobe end.
    @(negedge clk);
    addr = ~addr;
  endtask
endmodule
`default_nettype wire

/* File: verification/bad_decoder_bench.sv */
// Purpose: Self-checking bench for the board address decoder.
// Assumes: The processor model runs every bus cycle.
// Notes: Expected enables are rebuilt from the address map.
`timescale 1ns/1ps
`default_nettype none
module bad_decoder_bench;
  logic clk, rstn, ctl_data_jump, ctl_data_mem, mem_on, jump_on;
  logic [15:0] addr;
  logic io_not_mem, read_status, interrupt_ack_strobe_n, rd_strobe_n;
  logic wr_strobe_n, memory_write_strobe_n, internal_write_strobe_n;
  logic power_on_jump_enable, onboard_memory_enable;
  logic [6:0] en_n;
  int mismatches, tests_run;
  logic [7:0] mp[10] = '{8'h00, 8'h07, 8'h08, 8'hd0, 8'hd1, 8'hd2, 8'hd7,
                         8'hd8, 8'hdf, 8'he0};
  logic [7:0] io[12] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h12, 8'h13, 8'h14,
                         8'h15, 8'hf3, 8'hf2, 8'h06, 8'hd0};
  bad_decoder #(.SYS_TO_SERIAL(1'b1)) u_dut (.clk, .rstn, .clk_en(1'b1),
    .addr, .io_not_mem, .read_status, .interrupt_ack_strobe_n, .rd_strobe_n,
    .wr_strobe_n, .memory_write_strobe_n, .internal_write_strobe_n,
    .ctl_data_jump, .ctl_data_mem, .rom_en_n(en_n[6]), .ram_en_n(en_n[5]),
    .timer_en_n(en_n[4]), .parallel_en_n(en_n[3]), .serial_en_n(en_n[2]),
    .control_en_n(en_n[1]), .ram_timer_wr_n(en_n[0]),
    .power_on_jump_enable, .onboard_memory_enable);
  bad_cpu_model u_cpu (.clk, .en_n, .addr, .io_not_mem, .read_status,
    .interrupt_ack_strobe_n, .rd_strobe_n, .wr_strobe_n,
    .memory_write_strobe_n, .internal_write_strobe_n);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [6:0] got, input logic [6:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bit order: rom, ram, timer, parallel, serial, control, write strobe.
  function automatic logic [6:0] expv(logic [7:0] pg, logic o, logic rd,
                                      logic ack);
    logic [6:0] v;
    v = {6'h3f, rd};
    if (!ack && !o) begin
      if (pg >= 8'hd8 && pg <= 8'hdf && rd && mem_on) v[6] = 1'b0;
      if (pg <= 8'h07 && rd && jump_on) v[6] = 1'b0;
      if (pg == 8'hd0 && mem_on) v[5] = 1'b0;
      if (pg == 8'hd1 && mem_on) v[4] = 1'b0;
    end else if (!ack) begin
      if (pg[7:1] == 7'h0a) v[3] = 1'b0;
      if (pg[7:1] inside {7'h01, 7'h02, 7'h09}) v[2] = 1'b0;
      if (pg == 8'hf3) v[1] = 1'b0;
    end
    return v;
  endfunction
  task automatic run(input logic [7:0] pg, input logic o, input logic rd,
                     input logic ack);
    logic [6:0] seen;
    u_cpu.cycle(pg, o, rd, ack, seen);
    check(seen, expv(pg, o, rd, ack));
  endtask
  task automatic t_map();
    foreach (mp[i]) for (int r = 0; r < 2; r++) run(mp[i], 1'b0, r[0], 1'b0);
  endtask
  task automatic t_ports();
    foreach (io[i]) for (int r = 0; r < 2; r++) run(io[i], 1'b1, r[0], 1'b0);
  endtask
  task automatic t_ack();
    run(8'hd8, 1'b0, 1'b1, 1'b1);
    run(8'h00, 1'b0, 1'b1, 1'b1);
    run(8'hf3, 1'b1, 1'b1, 1'b1);
  endtask
  // The new control value must hold back for three further strobes.
  task automatic t_ctl(input logic jmp, input logic mem);
    logic [1:0] old;
    old = {power_on_jump_enable, onboard_memory_enable};
    ctl_data_jump = jmp;
    ctl_data_mem = mem;
    run(8'hf3, 1'b1, 1'b0, 1'b0);
    for (int k = 1; k <= 3; k++) begin
      run(8'h80, 1'b0, 1'b1, 1'b0);
      @(negedge clk);
      check({5'h00, power_on_jump_enable, onboard_memory_enable},
            {5'h00, (k == 3) ? {~jmp, ~mem} : old});
    end
    jump_on = ~jmp;
    mem_on = ~mem;
  endtask
  task automatic t_reset();
    rstn = 1'b0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    jump_on = 1'b1;
    mem_on = 1'b1;
    check({5'h00, power_on_jump_enable, onboard_memory_enable},
          7'h03);
  endtask
  initial begin
    mismatches = 0;
    tests_run = 0;
    ctl_data_jump = 1'b0;
    ctl_data_mem = 1'b0;
    t_reset();
    t_map();
    t_ports();
    t_ack();
    t_ctl(1'b0, 1'b1);
    t_map();
    t_ctl(1'b1, 1'b1);
    t_map();
    t_ports();
    t_ctl(1'b1, 1'b0);
    t_map();
    t_reset();
    t_map();
    give_verdict();
  end
  // ****************************************
  // Watchdog
  // ****************************************
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire
